// ==== bench/out_line_sva.sv ====
// Port checker for the output line controller
`timescale 1ns/10ps
`include "out_line_cfg.svh"
module out_line_sva #(
    parameter int MS_CYCLES = 10
) (
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input out_line_pkg::line_cfg_t     lineCfg,
    input out_line_pkg::diag_cfg_t     diagCfg,
    input out_line_pkg::read_evt_t     readEvt,
    input wire logic                   driverOn,
    input wire logic                   lineActive,
    input wire logic                   errorPresent,
    input wire logic [`FAULT_W-1:0]    faultStatus
);
    int actCnt;
    int limMs;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    assign limMs = (lineCfg.pulseMs < `PULSE_MIN_MS) ? 40 :
        (lineCfg.pulseMs > `PULSE_MAX_MS) ? 15000 : int'(lineCfg.pulseMs);
    always_ff @(posedge mclk) actCnt <= lineActive ? actCnt + 1 : 0;
    a_drive_polarity: assert property ($past(rst_n) |->
        driverOn == (lineActive ^ $past(lineCfg.normallyClosed))) else $error("bad drive");
    a_start_activates: assert property (!lineActive && readEvt.phaseStart &&
        (lineCfg.actPrimary == out_line_pkg::ACT_START || lineCfg.actSecondary == out_line_pkg::ACT_START)
        |=> lineActive) else $error("no start");
    a_stop_releases: assert property (lineActive && readEvt.phaseStop &&
        lineCfg.deactPrimary == out_line_pkg::DEACT_STOP |=> !lineActive) else $error("stop kept line");
    a_none_quiet: assert property (lineCfg.actPrimary == out_line_pkg::ACT_NONE && !lineActive &&
        lineCfg.actSecondary == out_line_pkg::ACT_NONE && !lineCfg.actOnFault |=> !lineActive)
        else $error("rose unselected");
    a_pulse_max: assert property (lineActive && lineCfg.deactPrimary == out_line_pkg::DEACT_TIMEOUT
        |-> actCnt <= (limMs + 1) * MS_CYCLES + 2) else $error("pulse too long");
    a_pulse_min: assert property ($fell(lineActive) && lineCfg.deactPrimary == out_line_pkg::DEACT_TIMEOUT
        && lineCfg.deactSecondary == out_line_pkg::DEACT_NONE && !lineCfg.releaseOnClear
        |-> actCnt >= (limMs - 1) * MS_CYCLES) else $error("pulse too short");
    a_fault_line: assert property ($rose(errorPresent) && lineCfg.actOnFault && !lineActive
        |=> lineActive) else $error("no fault rise");
    a_clear_release: assert property ($fell(errorPresent) && lineCfg.releaseOnClear && lineActive
        |=> !lineActive) else $error("no release");
    a_mask_holds: assert property ($stable(diagCfg.reportMask) |->
        (faultStatus & ~diagCfg.reportMask) == '0) else $error("mask leak");
    a_error_summary: assert property (errorPresent == (|faultStatus))
        else $error("summary wrong");
endmodule : out_line_sva

// ==== bench/read_event_source.sv ====
// Far side model: reading phase and decode event source
`timescale 1ns/10ps
`include "out_line_cfg.svh"
module read_event_source (
    input  wire logic          mclk,
    output out_line_pkg::read_evt_t readEvt
);
    initial readEvt = '0;
    task automatic pulse(input logic [1:0] ev);
        {readEvt.phaseStop, readEvt.phaseStart} = ev;
        @(negedge mclk);
        {readEvt.phaseStop, readEvt.phaseStart} = 2'b00;
    endtask : pulse
    task automatic decode(input logic [7:0] kind, input logic [31:0] code);
        {readEvt.decodeValid, readEvt.decodeType, readEvt.decodeData} = {1'b1, kind, code};
        @(negedge mclk);
        {readEvt.decodeValid, readEvt.decodeType, readEvt.decodeData} = {1'b0, ~kind, ~code};
    endtask : decode
endmodule : read_event_source

// ==== bench/test_event_driven_output_line_ctrl.sv ====
// Self-checking bench for the output line controller
`timescale 1ns/10ps
`include "out_line_cfg.svh"
module test_event_driven_output_line_ctrl;
    logic                    mclk = 1'b0;
    logic                    rst_n = 1'b0;
    out_line_pkg::line_cfg_t lineCfg = '0;
    out_line_pkg::diag_cfg_t diagCfg = '0;
    logic [`CODE_TYPES-1:0]  codeSelMask = 8'h03;
    logic [`CODE_W-1:0]      verifierCode = 32'hC0DE5A11;
    out_line_pkg::read_evt_t readEvt;
    logic [`FAULT_EXT-1:0]   faultIn = 8'h00;
    logic [`FAULT_EXT-1:0]   slaveFault = 8'h00;
    logic                    tachPin = 1'b0;
    logic                    presencePin = 1'b0;
    logic                    driverOn;
    logic                    lineActive;
    logic                    errorPresent;
    logic [`FAULT_W-1:0]     faultStatus;
    int                      fails = 0;
    int                      samples_checked = 0;
    int                      cycles = 0;
    always #50 mclk = ~mclk;
    read_event_source src (.mclk(mclk), .readEvt(readEvt));
    event_driven_output_line_ctrl #(.MS_CYCLES(10)) dut (.mclk, .rst_n, .lineCfg, .diagCfg,
        .codeSelMask, .verifierCode, .readEvt, .faultIn, .slaveFault, .tachPin, .presencePin,
        .driverOn, .lineActive, .errorPresent, .faultStatus);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic await_line(input logic exp, input int lim);
        for (int i = 0; i < lim; i++) begin
            if (exp && lineActive === 1'b1) break;
            @(negedge mclk);
        end
        check("lineActive", lineActive, exp);
    endtask : await_line
    task automatic s_start_stop;
        lineCfg.normallyClosed = 1'b1;
        lineCfg.actPrimary = out_line_pkg::ACT_START;
        lineCfg.deactPrimary = out_line_pkg::DEACT_STOP;
        @(negedge mclk);
        check("idle drive", driverOn, 1);
        src.pulse(2'b01);
        await_line(1, 4);
        check("active drive", driverOn, 0);
        src.pulse(2'b10);
        await_line(0, 4);
        check("released drive", driverOn, 1);
    endtask : s_start_stop
    task automatic s_reads;
        logic       t0 [12] = '{1, 1, 1, 0, 0, 0, 1, 1, 0, 0, 0, 0};
        logic [7:0] t1 [12] = '{8'h02, 0, 0, 0, 0, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
        logic       same [12] = '{1, 1, 1, 1, 1, 1, 1, 0, 1, 0, 0, 1};
        lineCfg.normallyClosed = 1'b0;
        lineCfg.actPrimary = out_line_pkg::ACT_NONE;
        lineCfg.deactPrimary = out_line_pkg::DEACT_START;
        for (int i = 0; i < 12; i++) begin
            lineCfg.actSecondary = out_line_pkg::act_sel_t'(4'(i < 6 ? i / 2 + 1 : i / 2 + 3));
            src.pulse(2'b01);
            await_line(0, 4);
            if (t0[i]) src.decode(8'h01, verifierCode);
            if (t1[i] != 0) src.decode(t1[i], same[i] ? verifierCode : ~verifierCode);
            src.pulse(2'b10);
            await_line(!i[0], 4);
        end
    endtask : s_reads
    task automatic s_timeout;
        int n = 102;
        lineCfg.actSecondary = out_line_pkg::ACT_NONE;
        lineCfg.actPrimary = out_line_pkg::ACT_START;
        lineCfg.deactPrimary = out_line_pkg::DEACT_TIMEOUT;
        lineCfg.pulseMs = 16'h0005;
        src.pulse(2'b01);
        await_line(1, 4);
        repeat (100) @(negedge mclk);
        src.pulse(2'b01);
        while (lineActive === 1'b1 && n < 900) begin
            @(negedge mclk);
            n++;
        end
        check("pulse cycles", n >= 385 && n <= 420, 1);
    endtask : s_timeout
    task automatic s_fault;
        lineCfg.actPrimary = out_line_pkg::ACT_NONE;
        lineCfg.deactPrimary = out_line_pkg::DEACT_NONE;
        lineCfg.actOnFault = 1'b1;
        lineCfg.releaseOnClear = 1'b1;
        diagCfg.sampleMs = 16'h0002;
        diagCfg.reportMask = 10'h302;
        diagCfg.slaveEn = 1'b1;
        faultIn = 8'h04;
        await_line(0, 60);
        check("masked status", faultStatus, 10'h000);
        slaveFault = 8'h02;
        await_line(1, 60);
        check("slave status", faultStatus, 10'h002);
        slaveFault = 8'h00;
        await_line(0, 60);
        diagCfg.tachStuckMs = 16'h0003;
        diagCfg.presStuckMs = 16'h0003;
        repeat (80) @(negedge mclk);
        check("stuck status", faultStatus, 10'h300);
        for (int i = 0; i < 24; i++) begin
            repeat (5) @(negedge mclk);
            tachPin = ~tachPin;
            presencePin = presencePin ^ (i < 12);
            if (i == 11) check("moving status", faultStatus, 10'h000);
        end
        check("moving tach status", faultStatus, 10'h200);
    endtask : s_fault
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(negedge mclk);
        check("reset drive", driverOn, 0);
        rst_n = 1'b1;
        s_start_stop();
        s_reads();
        s_timeout();
        s_fault();
        end_of_test();
    end
endmodule : test_event_driven_output_line_ctrl
bind event_driven_output_line_ctrl out_line_sva #(.MS_CYCLES(MS_CYCLES)) chk (.mclk, .rst_n,
    .lineCfg, .diagCfg, .readEvt, .driverOn, .lineActive, .errorPresent, .faultStatus);

// ==== common/out_line_cfg.svh ====
// Constants for the event driven output line controller
`ifndef OUT_LINE_CFG_SVH
`define OUT_LINE_CFG_SVH
`define CODE_TYPES     8
`define CODE_W         32
`define MS_W           16
`define FAULT_EXT      8
`define FAULT_W        10
`define FAULT_TACH     8
`define FAULT_PRES     9
`define STUCK_N        2
`define PULSE_MIN_MS   16'h0028
`define PULSE_MAX_MS   16'h3A98
`define CLK_PERIOD_NS  100
`define TICK_PERIOD_NS 1000000
`define CFG_RESET      1'h0
`endif

// ==== common/out_line_pkg.sv ====
// Types shared by the output line controller and its diagnostic monitor
`include "out_line_cfg.svh"
package out_line_pkg;
    typedef enum logic [3:0] {
        ACT_NONE     = 4'h0,
        ACT_COMPLETE = 4'h1,
        ACT_PARTIAL  = 4'h2,
        ACT_NOREAD   = 4'h3,
        ACT_START    = 4'h4,
        ACT_STOP     = 4'h5,
        ACT_REPEAT   = 4'h6,
        ACT_MATCH    = 4'h7,
        ACT_MISMATCH = 4'h8
    } act_sel_t;
    typedef enum logic [1:0] {
        DEACT_NONE    = 2'h0,
        DEACT_TIMEOUT = 2'h1,
        DEACT_START   = 2'h2,
        DEACT_STOP    = 2'h3
    } deact_sel_t;
    typedef enum logic [1:0] {
        LINE_IDLE   = 2'h1,
        LINE_ACTIVE = 2'h2
    } line_state_t;
    typedef struct packed {
        logic                 normallyClosed;
        act_sel_t             actPrimary;
        act_sel_t             actSecondary;
        logic                 actOnFault;
        deact_sel_t           deactPrimary;
        deact_sel_t           deactSecondary;
        logic                 releaseOnClear;
        logic [`MS_W-1:0]     pulseMs;
    } line_cfg_t;
    typedef struct packed {
        logic                   phaseStart;
        logic                   phaseStop;
        logic                   decodeValid;
        logic [`CODE_TYPES-1:0] decodeType;
        logic [`CODE_W-1:0]     decodeData;
    } read_evt_t;
    typedef struct packed {
        logic [`MS_W-1:0]    sampleMs;
        logic [`FAULT_W-1:0] reportMask;
        logic                slaveEn;
        logic [`MS_W-1:0]    tachStuckMs;
        logic [`MS_W-1:0]    presStuckMs;
    } diag_cfg_t;
endpackage : out_line_pkg

// ==== hdl/diag_monitor.sv ====
// Periodic fault poller with stuck tachometer and presence sensor detection
`timescale 1ns/10ps
`include "out_line_cfg.svh"
module diag_monitor (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   msTick,
    input  out_line_pkg::diag_cfg_t     diagCfg,
    input  wire logic [`FAULT_EXT-1:0]  faultIn,
    input  wire logic [`FAULT_EXT-1:0]  slaveFault,
    input  wire logic [`STUCK_N-1:0]    sensorLevel,
    output logic                        errorReport,
    output logic                        errorPresent,
    output logic [`FAULT_W-1:0]         faultStatus
);
    // ----------------------------------------------------------------
    // Stuck detection, tachometer in entry 0, presence sensor in entry 1
    // ----------------------------------------------------------------
    logic [`STUCK_N-1:0] stuck;
    logic [`STUCK_N-1:0] levelPrev_reg;
    logic [`MS_W-1:0]    limitMs [`STUCK_N];
    assign limitMs[0] = diagCfg.tachStuckMs;
    assign limitMs[1] = diagCfg.presStuckMs;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            levelPrev_reg <= '0;
        end else begin
            levelPrev_reg <= sensorLevel;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `STUCK_N; g = g + 1) begin : gStuck
            logic [`MS_W-1:0] idle_reg;
            // Any level change proves the sensor alive; counter saturates
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    idle_reg <= '0;
                end else if (sensorLevel[g] != levelPrev_reg[g]) begin
                    idle_reg <= '0;
                end else if (msTick && idle_reg != {`MS_W{1'b1}}) begin
                    idle_reg <= idle_reg + 16'h0001;
                end
            end
            // Zero interval means disabled [RULE_20] [RULE_21]
            assign stuck[g] = (limitMs[g] != '0) && (idle_reg >= limitMs[g]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Sampling timer and masked report
    // ----------------------------------------------------------------
    logic [`MS_W-1:0]    sampleCnt_reg;
    logic                sampleNow;
    logic [`FAULT_W-1:0] rawFault;
    assign sampleNow = msTick && (sampleCnt_reg + 16'h0001 >= diagCfg.sampleMs); // [RULE_17]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sampleCnt_reg <= '0;
        end else if (sampleNow) begin
            sampleCnt_reg <= '0;
        end else if (msTick) begin
            sampleCnt_reg <= sampleCnt_reg + 16'h0001;
        end
    end

    always_comb begin
        rawFault = {stuck[1], stuck[0], faultIn};
        if (diagCfg.slaveEn) begin
            rawFault[`FAULT_EXT-1:0] = faultIn | slaveFault; // [RULE_19]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            faultStatus  <= '0;
            errorPresent <= 1'b0;
            errorReport  <= 1'b0;
        end else begin
            errorReport <= 1'b0;
            if (sampleNow) begin
                faultStatus  <= rawFault & diagCfg.reportMask; // [RULE_18]
                errorPresent <= |(rawFault & diagCfg.reportMask);
                errorReport  <= |(rawFault & diagCfg.reportMask);
            end
        end
    end
endmodule : diag_monitor

// ==== hdl/event_driven_output_line_ctrl.sv ====
// One scanner digital output line driven by read events and diagnostics
//
// Overview of operation
// [RULE_01] A secondary activation selection also activates the line, from the same event set.
// [RULE_02] An activation selection of none never activates the line.
// [RULE_03] Complete read fires when every selected code type was decoded.
// [RULE_04] Partial read fires when some but not all selected codes were decoded.
// [RULE_05] No read fires when a reading phase ends with nothing decoded.
// [RULE_06] Phase begin fires on the start event, phase end on the stop event.
// [RULE_07] Repeat decode fires when the same code decodes twice in a row.
// [RULE_08] Verifier hit fires on a decode equal to the reference code.
// [RULE_09] Verifier miss fires on a decode differing from the reference code.
// [RULE_10] With assert on fault enabled, an error report activates the line.
// [RULE_11] Software should set other activation selections to none with assert on fault.
// [RULE_12] A deactivation selection of none gives no release condition.
// [RULE_13] Timeout releases the line after the programmed maximum pulse length.
// [RULE_14] Both deactivation selections can release on phase start or phase stop.
// [RULE_15] Release on fault clear drops the line when the error disappears.
// [RULE_16] Maximum pulse length is programmable from 40 to 15000 milliseconds.
// [RULE_17] Diagnostics poll fault status every programmable sampling time.
// [RULE_18] Each fault type has a report enable mask bit.
// [RULE_19] Slave reporting adds subordinate scanner faults to the poll.
// [RULE_20] A nonzero tachometer interval flags a tachometer without pulses that long.
// [RULE_21] A nonzero presence interval flags a presence sensor stuck that long.
// [RULE_22] Normally open drives the transistor on when active; normally closed reverses. Reset drives the transistor off in both modes.
// [RULE_23] All millisecond counters advance on a prescaled one millisecond tick.
// [RULE_24] Activation while active keeps the line on without restarting the pulse count.
`timescale 1ns/10ps
`include "out_line_cfg.svh"
module event_driven_output_line_ctrl #(
    parameter int MS_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  out_line_pkg::line_cfg_t     lineCfg,
    input  out_line_pkg::diag_cfg_t     diagCfg,
    input  wire logic [`CODE_TYPES-1:0] codeSelMask,
    input  wire logic [`CODE_W-1:0]     verifierCode,
    input  out_line_pkg::read_evt_t     readEvt,
    input  wire logic [`FAULT_EXT-1:0]  faultIn,
    input  wire logic [`FAULT_EXT-1:0]  slaveFault,
    input  wire logic                   tachPin,
    input  wire logic                   presencePin,
    output logic                        driverOn,
    output logic                        lineActive,
    output logic                        errorPresent,
    output logic [`FAULT_W-1:0]         faultStatus
);
    // ----------------------------------------------------------------
    // Millisecond prescaler
    // ----------------------------------------------------------------
    localparam logic [`MS_W-1:0] MS_LAST = `MS_W'(MS_CYCLES - 1);
    logic [`MS_W-1:0] prescale_reg;
    logic             msTick;
    assign msTick = (prescale_reg == MS_LAST);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_reg <= '0;
        end else if (msTick) begin
            prescale_reg <= '0; // [RULE_23]
        end else begin
            prescale_reg <= prescale_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers, two flops per sensor pin
    // ----------------------------------------------------------------
    logic [`STUCK_N-1:0] pinRaw;
    logic [`STUCK_N-1:0] pinMeta_reg;
    logic [`STUCK_N-1:0] pinSync_reg;
    assign pinRaw = {presencePin, tachPin};

    genvar g;
    generate
        for (g = 0; g < `STUCK_N; g = g + 1) begin : gSync
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    pinMeta_reg[g] <= 1'b0;
                    pinSync_reg[g] <= 1'b0;
                end else begin
                    pinMeta_reg[g] <= pinRaw[g];
                    pinSync_reg[g] <= pinMeta_reg[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Diagnostic monitor
    // ----------------------------------------------------------------
    logic errorReport;

    diag_monitor uDiag (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .msTick       (msTick),
        .diagCfg      (diagCfg),
        .faultIn      (faultIn),
        .slaveFault   (slaveFault),
        .sensorLevel  (pinSync_reg),
        .errorReport  (errorReport),
        .errorPresent (errorPresent),
        .faultStatus  (faultStatus)
    );

    // ----------------------------------------------------------------
    // Reading phase bookkeeping
    // ----------------------------------------------------------------
    logic                   inPhase_reg;
    logic [`CODE_TYPES-1:0] decoded_reg;
    logic [`CODE_TYPES-1:0] seen;
    logic [`CODE_TYPES-1:0] seenSel;
    logic                   stopNow;
    logic                   startNow;

    assign startNow = readEvt.phaseStart;
    assign stopNow  = readEvt.phaseStop && inPhase_reg;
    // A decode landing with the stop still counts for this phase
    assign seen     = decoded_reg | (readEvt.decodeValid ? readEvt.decodeType : '0);
    assign seenSel  = seen & codeSelMask;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inPhase_reg <= 1'b0;
        end else if (startNow) begin
            inPhase_reg <= 1'b1;
        end else if (readEvt.phaseStop) begin
            inPhase_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            decoded_reg <= '0;
        end else if (startNow) begin
            decoded_reg <= '0;
        end else if (readEvt.decodeValid && inPhase_reg) begin
            decoded_reg <= seen;
        end
    end

    // ----------------------------------------------------------------
    // Decode comparison for repeat and verifier events
    // ----------------------------------------------------------------
    logic [`CODE_W-1:0] lastCode_reg;
    logic               lastValid_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lastCode_reg  <= '0;
            lastValid_reg <= 1'b0;
        end else if (startNow) begin
            lastValid_reg <= 1'b0;
        end else if (readEvt.decodeValid) begin
            lastCode_reg  <= readEvt.decodeData;
            lastValid_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Activation event vector, indexed by selection code
    // ----------------------------------------------------------------
    logic [8:0] evt;
    logic       completeRd;

    assign completeRd = stopNow && (codeSelMask != '0) && (seenSel == codeSelMask);

    always_comb begin
        evt                           = '0;
        evt[out_line_pkg::ACT_COMPLETE] = completeRd; // [RULE_03]
        evt[out_line_pkg::ACT_PARTIAL]  = stopNow && (seenSel != '0) && !completeRd; // [RULE_04]
        evt[out_line_pkg::ACT_NOREAD]   = stopNow && (seen == '0); // [RULE_05]
        evt[out_line_pkg::ACT_START]    = startNow; // [RULE_06]
        evt[out_line_pkg::ACT_STOP]     = readEvt.phaseStop; // [RULE_06]
        evt[out_line_pkg::ACT_REPEAT]   = readEvt.decodeValid && lastValid_reg
                                          && (readEvt.decodeData == lastCode_reg); // [RULE_07]
        evt[out_line_pkg::ACT_MATCH]    = readEvt.decodeValid
                                          && (readEvt.decodeData == verifierCode); // [RULE_08]
        evt[out_line_pkg::ACT_MISMATCH] = readEvt.decodeValid
                                          && (readEvt.decodeData != verifierCode); // [RULE_09]
    end

    function automatic logic actHit(input out_line_pkg::act_sel_t sel,
                                    input logic [8:0] ev);
        logic hit;
        hit = 1'b0;
        case (sel)
            out_line_pkg::ACT_NONE:     hit = 1'b0; // [RULE_02]
            out_line_pkg::ACT_COMPLETE: hit = ev[1];
            out_line_pkg::ACT_PARTIAL:  hit = ev[2];
            out_line_pkg::ACT_NOREAD:   hit = ev[3];
            out_line_pkg::ACT_START:    hit = ev[4];
            out_line_pkg::ACT_STOP:     hit = ev[5];
            out_line_pkg::ACT_REPEAT:   hit = ev[6];
            out_line_pkg::ACT_MATCH:    hit = ev[7];
            out_line_pkg::ACT_MISMATCH: hit = ev[8];
            default:                    hit = 1'b0;
        endcase
        return hit;
    endfunction : actHit

    // Secondary never selects a timeout; treat that code as none
    function automatic logic deactHit(input out_line_pkg::deact_sel_t sel,
                                      input logic timedOut,
                                      input logic startEv,
                                      input logic stopEv);
        logic hit;
        hit = 1'b0;
        case (sel)
            out_line_pkg::DEACT_NONE:    hit = 1'b0; // [RULE_12]
            out_line_pkg::DEACT_TIMEOUT: hit = timedOut; // [RULE_13]
            out_line_pkg::DEACT_START:   hit = startEv; // [RULE_14]
            out_line_pkg::DEACT_STOP:    hit = stopEv; // [RULE_14]
            default:                     hit = 1'b0;
        endcase
        return hit;
    endfunction : deactHit

    // ----------------------------------------------------------------
    // Pulse length limit, held inside its legal range
    // ----------------------------------------------------------------
    logic [`MS_W-1:0] pulseLimit;

    always_comb begin
        pulseLimit = lineCfg.pulseMs;
        if (lineCfg.pulseMs < `PULSE_MIN_MS) begin
            pulseLimit = `PULSE_MIN_MS; // [RULE_16]
        end else if (lineCfg.pulseMs > `PULSE_MAX_MS) begin
            pulseLimit = `PULSE_MAX_MS; // [RULE_16]
        end
    end

    // ----------------------------------------------------------------
    // Activation and release terms
    // ----------------------------------------------------------------
    logic             activate;
    logic             release_;
    logic             timedOut;
    logic             faultCleared;
    logic             errPrev_reg;
    logic [`MS_W-1:0] pulseCnt_reg;

    assign activate = actHit(lineCfg.actPrimary, evt)
                    | actHit(lineCfg.actSecondary, evt) // [RULE_01]
                    | (lineCfg.actOnFault && errorReport); // [RULE_10]

    assign timedOut     = (pulseCnt_reg >= pulseLimit);
    assign faultCleared = lineCfg.releaseOnClear && errPrev_reg && !errorPresent; // [RULE_15]

    always_comb begin
        release_ = deactHit(lineCfg.deactPrimary, timedOut, startNow, readEvt.phaseStop)
                 | faultCleared;
        if (lineCfg.deactSecondary != out_line_pkg::DEACT_TIMEOUT) begin
            release_ = release_ | deactHit(lineCfg.deactSecondary, 1'b0,
                                           startNow, readEvt.phaseStop); // [RULE_14]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            errPrev_reg <= 1'b0;
        end else begin
            errPrev_reg <= errorPresent;
        end
    end

    // ----------------------------------------------------------------
    // Line state machine
    // ----------------------------------------------------------------
    out_line_pkg::line_state_t state_reg;
    out_line_pkg::line_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            out_line_pkg::LINE_IDLE: begin
                if (activate) begin
                    state_next = out_line_pkg::LINE_ACTIVE;
                end
            end
            out_line_pkg::LINE_ACTIVE: begin
                // Release wins over a coincident activation to keep pulses bounded
                if (release_) begin
                    state_next = out_line_pkg::LINE_IDLE;
                end
            end
            default: state_next = out_line_pkg::LINE_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= out_line_pkg::LINE_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Count only runs while active; a fresh activation in idle restarts it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pulseCnt_reg <= '0;
        end else if (state_reg != out_line_pkg::LINE_ACTIVE) begin
            pulseCnt_reg <= '0;
        end else if (msTick && !timedOut) begin
            pulseCnt_reg <= pulseCnt_reg + 16'h0001; // [RULE_24] [RULE_23]
        end
    end

    // ----------------------------------------------------------------
    // Driver polarity
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            driverOn   <= `CFG_RESET;
            lineActive <= 1'b0;
        end else begin
            lineActive <= (state_next == out_line_pkg::LINE_ACTIVE);
            driverOn   <= (state_next == out_line_pkg::LINE_ACTIVE)
                          ^ lineCfg.normallyClosed; // [RULE_22]
        end
    end
endmodule : event_driven_output_line_ctrl
